// file: logic/rfmw_mem.sv
// Tag memory: data words with one lock bit per byte
`timescale 1ns/1ps
module rfmw_mem #(
  parameter int IDX_W = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [IDX_W-1:0] idx,
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_be,
  input  wire logic [31:0]      wr_data,
  input  wire logic [3:0]       lk_set,
  output logic      [31:0]      rd_data_reg,
  output logic      [3:0]       rd_lock_reg
);
  localparam int DEPTH = 1 << IDX_W;
  logic [31:0] mem [DEPTH];
  logic [3:0]  lock_mem [DEPTH];

  // Byte-lane programming; cells have no reset, like the nonvolatile array
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (wr_en && wr_be[i]) begin
        mem[idx][8*i +: 8] <= wr_data[8*i +: 8];
      end
    end
  end

  // Lock bits only ever set; read port registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < DEPTH; j++) begin
        lock_mem[j] <= 4'h0;
      end
      rd_data_reg <= 32'h0000_0000;
      rd_lock_reg <= 4'h0;
    end else begin
      lock_mem[idx] <= lock_mem[idx] | lk_set;
      rd_data_reg   <= mem[idx];
      rd_lock_reg   <= lock_mem[idx];
    end
  end
endmodule

// file: logic/rfmw_pkg.sv
// Constants and types of the tag multi-write command interpreter
//
// Behaviour
// [RL1] Lock query answers ack-ok, ack-failed, locked-ok or locked-failed from write flag
// [RL2] Broadcast byte write programs an unlocked byte and leaves a locked one alone
// [RL3] Each broadcast write sets the write flag on success, clears it otherwise
// [RL4] Broadcast writes never produce a reply
// [RL5] Reader frames broadcast writes with the single delimiter and no tag ID
// [RL6] Broadcast word write is taken only in arbitration or exchange state
// [RL7] Masked word write programs only bytes picked by mask bits B7 to B4
// [RL8] Reader aligns the broadcast word write address to a four-byte page
// [RL9] Alternate delimiter selects the fast reply at four times forward rate
// [RL10] Fast replies carry one don't-care data byte outside the CRC, two CRC bytes
// [RL11] Reader ignores the fast reply data byte and decodes only the CRC
// [RL12] Fast reply CRC is a fixed value for each reply type
// [RL13] Fast flag-port read codes port 0 flags in the CRC, other ports 1E0F
// [RL14] Only write flag and exchange bit exist, every other flag reads zero
// [RL15] Reader waits the minimum programming time after any programming command; the reader model polls the busy bit after every command instead
// [RL16] Port 0 holds write flag in bit 1 and exchange bit in bit 0
// [RL17] Commands with a bad CRC are dropped with no write and no flag change
package rfmw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_REPLY  = 8'h14;
  localparam logic [7:0] OFS_PEEK   = 8'h18;
  localparam logic [7:0] OFS_LOCKS  = 8'h1c;
  // Command register fields, opcode in bits 3:0
  localparam int CMD_FAST = 4;
  localparam int CMD_UID  = 5;
  localparam int CMD_CRC  = 6;
  localparam int CMD_GO   = 7;
  // Address register: mask byte position
  localparam int ADDR_MASK_LSB = 8;
  // Status register fields, tag state in bits 5:4
  localparam int ST_BUSY   = 0;
  localparam int ST_EXCH   = 1;
  localparam int ST_WOK    = 2;
  localparam int ST_RVALID = 3;
  localparam int ST_TSTATE = 4;
  // Reply register fields
  localparam int RP_FAST    = 8;
  localparam int RP_CRC_LSB = 16;
  // Opcodes
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_WORD  = 4'h2;
  localparam logic [3:0] OP_LOCK  = 4'h3;
  localparam logic [3:0] OP_QUERY = 4'h4;
  localparam logic [3:0] OP_PORT  = 4'h5;
  localparam logic [3:0] OP_MBYTE = 4'h6;
  localparam logic [3:0] OP_MWORD = 4'h7;
  // Tag protocol states
  localparam logic [1:0] TS_READY = 2'h0;
  localparam logic [1:0] TS_ARB   = 2'h1;
  localparam logic [1:0] TS_EXCH  = 2'h2;
  // Values after reset
  localparam logic       RST_WOK    = 1'b0;
  localparam logic [1:0] RST_TSTATE = TS_READY;
  // Normal-mode reply codes, values arbitrary
  localparam logic [7:0] CODE_ACK    = 8'ha0;
  localparam logic [7:0] CODE_ACK_NG = 8'ha1;
  localparam logic [7:0] CODE_ACK_OK = 8'ha2;
  localparam logic [7:0] CODE_ERR    = 8'he0;
  localparam logic [7:0] CODE_LK_NG  = 8'he1;
  localparam logic [7:0] CODE_LK_OK  = 8'he2;
  // Fast-mode fixed CRC values and filler byte
  localparam logic [15:0] CRC_ACK    = 16'h1e0f;
  localparam logic [15:0] CRC_ACK_OK = 16'h0e2e;
  localparam logic [15:0] CRC_ERR    = 16'h00ff;
  localparam logic [15:0] CRC_LK_OK  = 16'h10de;
  localparam logic [15:0] CRC_PORT_W = 16'h3e4d;
  localparam logic [15:0] CRC_PORT_B = 16'h2e6c;
  localparam logic [7:0]  FAST_FILL  = 8'h00;
  typedef enum logic [2:0] {
    RK_ACK, RK_ACK_NG, RK_ACK_OK, RK_ERR, RK_LK_NG, RK_LK_OK, RK_PORT
  } rfmw_reply_type;
endpackage

// file: logic/rfmw_reply_enc.sv
// Reply encoder: data byte and CRC field for each reply kind
`timescale 1ns/1ps
module rfmw_reply_enc (
  input  wire rfmw_pkg::rfmw_reply_type kind,
  input  wire logic                     fast,
  input  wire logic                     port_zero,
  input  wire logic                     wok,
  input  wire logic                     exch,
  output logic                  [7:0]   data,
  output logic                  [15:0]  crc
);
  logic [7:0]  code;
  logic [15:0] fcrc;

  // Per-kind normal code and fast-mode CRC
  always_comb begin
    code = rfmw_pkg::CODE_ACK;
    fcrc = rfmw_pkg::CRC_ACK;
    case (kind)
      rfmw_pkg::RK_ACK_NG: code = rfmw_pkg::CODE_ACK_NG; // see RL12
      rfmw_pkg::RK_ACK_OK: begin
        code = rfmw_pkg::CODE_ACK_OK;
        fcrc = rfmw_pkg::CRC_ACK_OK; // see RL12
      end
      rfmw_pkg::RK_ERR: begin
        code = rfmw_pkg::CODE_ERR;
        fcrc = rfmw_pkg::CRC_ERR;
      end
      rfmw_pkg::RK_LK_NG: begin
        code = rfmw_pkg::CODE_LK_NG;
        fcrc = rfmw_pkg::CRC_ERR;
      end
      rfmw_pkg::RK_LK_OK: begin
        code = rfmw_pkg::CODE_LK_OK;
        fcrc = rfmw_pkg::CRC_LK_OK;
      end
      rfmw_pkg::RK_PORT: begin
        // Only two flags live here, the rest stay zero
        code = port_zero ? {6'h00, wok, exch} : 8'h00; // see RL14, RL16
        if (port_zero) begin
          case ({wok, exch}) // see RL13
            2'b01:   fcrc = rfmw_pkg::CRC_ACK_OK;
            2'b10:   fcrc = rfmw_pkg::CRC_PORT_W;
            2'b11:   fcrc = rfmw_pkg::CRC_PORT_B;
            default: fcrc = rfmw_pkg::CRC_ACK;
          endcase
        end
      end
      default: code = rfmw_pkg::CODE_ACK;
    endcase
  end

  // Fast mode: filler data, result only in CRC; normal CRC added by the link
  assign data = fast ? rfmw_pkg::FAST_FILL : code; // see RL10
  assign crc  = fast ? fcrc : 16'h0000; // see RL9
endmodule

// file: logic/rfmw_top.sv
// Tag command interpreter: broadcast writes, lock query, fast replies
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rfmw_top #(
  parameter int IDX_W = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC} rfmw_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  rfmw_state_type          state_reg;
  logic            [6:0]   cmd_reg;
  logic            [7:0]   addr_reg;
  logic            [7:0]   mask_reg;
  logic            [31:0]  data_reg;
  logic            [1:0]   tstate_reg;
  logic                    wok_reg;
  logic                    rvalid_reg;
  logic            [7:0]   rbyte_reg;
  logic            [15:0]  rcrc_reg;
  logic                    rfast_reg;
  rfmw_pkg::rfmw_reply_type rkind_reg;
  logic            [31:0]  prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic            [31:0]  rd_data;
  logic            [3:0]   rd_lock;
  logic            [31:0]  rd_mux;
  logic                    rd_hit;
  logic                    acc_done;
  logic                    wr_done;
  logic                    go;
  logic                    busy;
  logic                    exec;
  logic            [3:0]   opcode;
  logic                    fast;
  logic                    uid_hit;
  logic                    crc_ok;
  logic                    arb_ok;
  logic            [3:0]   lanes;
  logic            [3:0]   one_lane;
  logic                    lock_b;
  logic                    lock_w;
  logic                    ex_wr;
  logic            [3:0]   ex_be;
  logic            [31:0]  ex_wdata;
  logic            [3:0]   ex_lk;
  logic                    ex_reply;
  rfmw_pkg::rfmw_reply_type ex_kind;
  logic                    ex_wok_upd;
  logic                    ex_wok_val;
  logic                    ex_exch;
  logic            [7:0]   enc_data;
  logic            [15:0]  enc_crc;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One-hot byte lane from the low address bits
  function automatic logic [3:0] lane_onehot(input logic [1:0] a);
    lane_onehot = 4'h1 << a;
  endfunction

  // Mask bit B7 picks lane 0 (address+0) down to B4 for lane 3
  function automatic logic [3:0] mask_lanes(input logic [7:0] m);
    mask_lanes = {m[4], m[5], m[6], m[7]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Completion edge: access phase with pready already high
  assign acc_done = psel && penable && pready_reg;
  assign wr_done  = acc_done && pwrite;
  assign busy     = (state_reg != S_IDLE);
  assign go       = wr_done && (paddr == rfmw_pkg::OFS_CMD)
                    && pwdata[rfmw_pkg::CMD_GO] && !busy;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
    end
  end

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      rfmw_pkg::OFS_CMD:    rd_mux = {25'h000_0000, cmd_reg};
      rfmw_pkg::OFS_ADDR:   rd_mux = {16'h0000, mask_reg, addr_reg};
      rfmw_pkg::OFS_DATA:   rd_mux = data_reg;
      rfmw_pkg::OFS_STATE:  rd_mux = {30'h0000_0000, tstate_reg};
      rfmw_pkg::OFS_STATUS: begin
        rd_mux[rfmw_pkg::ST_BUSY]   = busy;
        rd_mux[rfmw_pkg::ST_EXCH]   = (tstate_reg == rfmw_pkg::TS_EXCH);
        rd_mux[rfmw_pkg::ST_WOK]    = wok_reg;
        rd_mux[rfmw_pkg::ST_RVALID] = rvalid_reg;
        rd_mux[rfmw_pkg::ST_TSTATE +: 2] = tstate_reg;
      end
      rfmw_pkg::OFS_REPLY: begin
        rd_mux[7:0] = rbyte_reg;
        rd_mux[rfmw_pkg::RP_FAST] = rfast_reg;
        rd_mux[rfmw_pkg::RP_CRC_LSB +: 16] = rcrc_reg;
      end
      rfmw_pkg::OFS_PEEK:   rd_mux = rd_data;
      rfmw_pkg::OFS_LOCKS:  rd_mux = {28'h000_0000, rd_lock};
      default:              rd_hit = 1'b0;
    endcase
  end

  // Read data and error latched with pready, held afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !rd_hit;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command fields; frozen while a command runs so the decision is stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg  <= 7'h00;
      addr_reg <= 8'h00;
      mask_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
    end else if (wr_done && !busy) begin
      case (paddr)
        rfmw_pkg::OFS_CMD:  cmd_reg <= pwdata[6:0];
        rfmw_pkg::OFS_ADDR: begin
          addr_reg <= pwdata[7:0];
          mask_reg <= pwdata[rfmw_pkg::ADDR_MASK_LSB +: 8];
        end
        rfmw_pkg::OFS_DATA: data_reg <= pwdata;
        default:            data_reg <= data_reg;
      endcase
    end
  end

  assign opcode  = cmd_reg[3:0];
  assign fast    = cmd_reg[rfmw_pkg::CMD_FAST];
  assign uid_hit = cmd_reg[rfmw_pkg::CMD_UID];
  assign crc_ok  = cmd_reg[rfmw_pkg::CMD_CRC];
  assign exec    = (state_reg == S_EXEC);
  assign arb_ok  = (tstate_reg == rfmw_pkg::TS_ARB)
                   || (tstate_reg == rfmw_pkg::TS_EXCH);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: fetch word and locks, then decide in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE:  state_reg <= go ? S_FETCH : S_IDLE;
        S_FETCH: state_reg <= S_EXEC;
        S_EXEC:  state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Word index ignores the low bits: page alignment is up to the reader
  rfmw_mem #(
    .IDX_W (IDX_W)
  ) u_mem (
    .clk         (pclk),
    .rst_n       (presetn),
    .idx         (addr_reg[IDX_W+1:2]), // see RL8
    .wr_en       (ex_wr),
    .wr_be       (ex_be),
    .wr_data     (ex_wdata),
    .lk_set      (ex_lk),
    .rd_data_reg (rd_data),
    .rd_lock_reg (rd_lock)
  );

  // Lock view of the addressed byte and of the masked word
  assign one_lane = lane_onehot(addr_reg[1:0]);
  assign lanes    = mask_lanes(mask_reg);
  assign lock_b   = |(rd_lock & one_lane);
  assign lock_w   = |(rd_lock & lanes);

  // Command decision; nothing happens unless the frame CRC checked
  always_comb begin
    ex_wr      = 1'b0;
    ex_be      = 4'h0;
    ex_wdata   = {4{data_reg[7:0]}};
    ex_lk      = 4'h0;
    ex_reply   = 1'b0;
    ex_kind    = rfmw_pkg::RK_ACK;
    ex_wok_upd = 1'b0;
    ex_wok_val = 1'b0;
    ex_exch    = 1'b0;
    if (exec && crc_ok) begin // see RL17
      case (opcode)
        rfmw_pkg::OP_WRITE: if (uid_hit) begin
          ex_exch    = 1'b1;
          ex_reply   = 1'b1;
          ex_wok_upd = 1'b1;
          ex_kind    = lock_b ? rfmw_pkg::RK_ERR : rfmw_pkg::RK_ACK;
          ex_wr      = !lock_b;
          ex_be      = one_lane;
          ex_wok_val = !lock_b;
        end
        rfmw_pkg::OP_WORD: if (uid_hit) begin
          ex_exch    = 1'b1;
          ex_reply   = 1'b1;
          ex_wok_upd = 1'b1;
          ex_kind    = lock_w ? rfmw_pkg::RK_ERR : rfmw_pkg::RK_ACK;
          ex_wr      = !lock_w;
          ex_be      = lanes;
          ex_wdata   = data_reg;
          ex_wok_val = !lock_w;
        end
        // Lock only from the exchange state
        rfmw_pkg::OP_LOCK: if (uid_hit && tstate_reg == rfmw_pkg::TS_EXCH) begin
          ex_reply   = 1'b1;
          ex_lk      = one_lane;
          ex_wok_upd = 1'b1;
          ex_wok_val = 1'b1;
        end
        rfmw_pkg::OP_QUERY: if (uid_hit) begin
          ex_exch  = 1'b1;
          ex_reply = 1'b1;
          if (lock_b) begin // see RL1
            ex_kind = wok_reg ? rfmw_pkg::RK_LK_OK : rfmw_pkg::RK_LK_NG;
          end else begin
            ex_kind = wok_reg ? rfmw_pkg::RK_ACK_OK : rfmw_pkg::RK_ACK_NG;
          end
        end
        rfmw_pkg::OP_PORT: if (uid_hit) begin
          ex_exch  = 1'b1;
          ex_reply = 1'b1;
          ex_kind  = rfmw_pkg::RK_PORT;
        end
        // Broadcast writes: silent, state-gated, flag follows the outcome
        rfmw_pkg::OP_MBYTE: if (arb_ok) begin
          ex_wok_upd = 1'b1; // see RL3
          ex_wok_val = !lock_b;
          ex_wr      = !lock_b; // see RL2
          ex_be      = one_lane;
        end
        rfmw_pkg::OP_MWORD: if (arb_ok) begin // see RL6
          ex_wok_upd = 1'b1; // see RL3
          ex_wok_val = !lock_w;
          ex_wr      = !lock_w;
          ex_be      = lanes; // see RL7
          ex_wdata   = data_reg;
        end
        default: ex_reply = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and tag state

  // Write flag; only a decided command touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wok_reg <= rfmw_pkg::RST_WOK;
    end else if (ex_wok_upd) begin
      wok_reg <= ex_wok_val; // see RL3
    end
  end

  // Tag state: software sets it when idle, addressed hits move to exchange
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstate_reg <= rfmw_pkg::RST_TSTATE;
    end else if (ex_exch) begin
      tstate_reg <= rfmw_pkg::TS_EXCH;
    end else if (wr_done && !busy && paddr == rfmw_pkg::OFS_STATE) begin
      tstate_reg <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply builder; port flags are the values before this command
  rfmw_reply_enc u_enc (
    .kind      (ex_kind),
    .fast      (fast),
    .port_zero (addr_reg == 8'h00),
    .wok       (wok_reg),
    .exch      (tstate_reg == rfmw_pkg::TS_EXCH),
    .data      (enc_data),
    .crc       (enc_crc)
  );

  // Reply latched at decision; a new command clears the valid flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rvalid_reg <= 1'b0;
      rbyte_reg  <= 8'h00;
      rcrc_reg   <= 16'h0000;
      rfast_reg  <= 1'b0;
      rkind_reg  <= rfmw_pkg::RK_ACK;
    end else if (ex_reply) begin
      rvalid_reg <= 1'b1; // see RL4
      rbyte_reg  <= enc_data;
      rcrc_reg   <= enc_crc;
      rfast_reg  <= fast; // see RL9
      rkind_reg  <= ex_kind;
    end else if (go) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go_multi;
    go && (pwdata[3:0] == rfmw_pkg::OP_MBYTE || pwdata[3:0] == rfmw_pkg::OP_MWORD);
  endsequence

  sequence s_run;
    state_reg == S_FETCH ##1 state_reg == S_EXEC ##1 state_reg == S_IDLE;
  endsequence

  sequence s_bad_exec;
    exec && !crc_ok;
  endsequence

  a_multi_silent: assert property (s_go_multi |=> s_run ##0 !rvalid_reg) // see RL4
    else $error("broadcast write produced a reply");

  a_query_code: assert property (exec && crc_ok && opcode == rfmw_pkg::OP_QUERY
      && uid_hit |=> rvalid_reg && rkind_reg == (lock_b ? ($past(wok_reg)
      ? rfmw_pkg::RK_LK_OK : rfmw_pkg::RK_LK_NG) : ($past(wok_reg)
      ? rfmw_pkg::RK_ACK_OK : rfmw_pkg::RK_ACK_NG))) // see RL1
    else $error("lock query reply kind wrong");

  a_byte_locked: assert property (exec && crc_ok && opcode == rfmw_pkg::OP_MBYTE
      && arb_ok && lock_b |-> !ex_wr ##1 !wok_reg) // see RL2
    else $error("locked byte programmed or flag kept");

  a_flag_result: assert property (exec && crc_ok && arb_ok
      && opcode == rfmw_pkg::OP_MWORD |=> wok_reg == !$past(lock_w)) // see RL3
    else $error("write flag does not follow result");

  a_word_gate: assert property (exec && opcode == rfmw_pkg::OP_MWORD
      && tstate_reg == rfmw_pkg::TS_READY |-> !ex_wr ##1 $stable(wok_reg)) // see RL6
    else $error("word write taken in ready state");

  a_mask_lanes: assert property (ex_wr && opcode == rfmw_pkg::OP_MWORD
      |-> ex_be == {mask_reg[4], mask_reg[5], mask_reg[6], mask_reg[7]}) // see RL7
    else $error("mask lanes wrong");

  a_fast_fill: assert property ($rose(rvalid_reg) && rfast_reg
      |-> rbyte_reg == rfmw_pkg::FAST_FILL) // see RL10
    else $error("fast reply data byte not filler");

  a_fast_crc: assert property ($rose(rvalid_reg) && rfast_reg
      && rkind_reg == rfmw_pkg::RK_ACK_OK |-> rcrc_reg == 16'h0e2e) // see RL12
    else $error("fast ack-ok CRC wrong");

  a_port_crc: assert property (exec && crc_ok && uid_hit && fast
      && opcode == rfmw_pkg::OP_PORT && addr_reg == 8'h00 && wok_reg
      && tstate_reg == rfmw_pkg::TS_EXCH |=> rcrc_reg == 16'h2e6c) // see RL13
    else $error("fast port CRC wrong");

  a_port_zero: assert property (rvalid_reg && !rfast_reg
      && rkind_reg == rfmw_pkg::RK_PORT |-> rbyte_reg[7:2] == 6'h00) // see RL14
    else $error("unused port flag set");

  a_bad_crc: assert property (s_bad_exec |-> !ex_wr && ex_lk == 4'h0
      ##1 $stable(wok_reg) && !rvalid_reg) // see RL17
    else $error("bad CRC command had an effect");
endmodule

// file: verif/rfmw_reader.sv
// Interrogator model: frames tag commands as register traffic
`timescale 1ns/1ps
module rfmw_reader (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             hung
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One transfer, held until pready is sampled; a stuck slave raises hung
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) hung <= 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Command frame with no tag ID for broadcasts; busy poll stands in for the wait
  task automatic cmd(input logic [3:0] op, input logic fast, input logic stored_tag_identifier,
                     input logic ok, input logic [15:0] adr, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    int          n;
    xfer(1'b1, rfmw_pkg::OFS_ADDR, {16'h0000, adr}, rd, e);
    xfer(1'b1, rfmw_pkg::OFS_DATA, d, rd, e);
    xfer(1'b1, rfmw_pkg::OFS_CMD, {24'h00_0000, 1'b1, ok, stored_tag_identifier, fast, op}, rd, e);
    n = 0;
    do begin
      xfer(1'b0, rfmw_pkg::OFS_STATUS, 32'h0000_0000, rd, e);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (n == 20) hung <= 1'b1;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the tag command interpreter
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hung;
  logic [31:0] d;
  logic        e;
  int          mismatches = 0;
  int          n_compared = 0;

  rfmw_top rfmw_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rfmw_reader rfmw_reader_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hung(hung));

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rfmw_reader_i.xfer(1'b0, a, 32'h0000_0000, d, e);
    chk("register", exp, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    rfmw_reader_i.xfer(1'b1, a, v, d, e);
  endtask
  // Memory word seen through the peek window
  task automatic peek(input logic [31:0] exp);
    wr(rfmw_pkg::OFS_ADDR, 32'h0000_0010);
    rd(rfmw_pkg::OFS_PEEK, exp);
  endtask
  // Reply-valid and write flag only; other status bits are left alone
  task automatic flags(input logic [1:0] exp);
    rfmw_reader_i.xfer(1'b0, rfmw_pkg::OFS_STATUS, 32'h0000_0000, d, e);
    chk("flags", {30'h0000_0000, exp}, {30'h0000_0000, d[3:2]});
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A stuck handshake ends the run
  always @(posedge hung) begin
    mismatches++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(rfmw_pkg::OFS_STATUS, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h0000_0000);
    wr(rfmw_pkg::OFS_STATE, 32'h0000_0001);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MWORD, 0, 0, 1, 16'hf010, 32'h0000_0000);
    flags(2'b01);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MBYTE, 0, 0, 1, 16'h0011, 32'h0000_005a);
    peek(32'h0000_5a00);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MWORD, 0, 0, 1, 16'ha010, 32'h4433_2211);
    peek(32'h0033_5a11);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MBYTE, 0, 0, 0, 16'h0010, 32'h0000_00ff);
    peek(32'h0033_5a11);
    wr(rfmw_pkg::OFS_STATE, 32'h0000_0000);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MBYTE, 0, 0, 1, 16'h0010, 32'h0000_00ff);
    peek(32'h0033_5a11);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MWORD, 0, 0, 1, 16'hf010, 32'hffff_ffff);
    peek(32'h0033_5a11);
    flags(2'b01);
    wr(rfmw_pkg::OFS_STATE, 32'h0000_0002);
    rfmw_reader_i.cmd(rfmw_pkg::OP_LOCK, 0, 1, 1, 16'h0010, 32'h0000_0000);
    rd(rfmw_pkg::OFS_LOCKS, 32'h0000_0001);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MBYTE, 0, 0, 1, 16'h0010, 32'h0000_00ff);
    peek(32'h0033_5a11);
    flags(2'b00);
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 0, 1, 1, 16'h0010, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h0000_00e1);
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 1, 1, 1, 16'h0011, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h1e0f_0100);
    rfmw_reader_i.cmd(rfmw_pkg::OP_MBYTE, 0, 0, 1, 16'h0011, 32'h0000_0077);
    peek(32'h0033_7711);
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 1, 1, 1, 16'h0010, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h10de_0100);
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 0, 1, 1, 16'h0011, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h0000_00a2);
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 1, 1, 1, 16'h0011, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h0e2e_0100);
    rfmw_reader_i.cmd(rfmw_pkg::OP_PORT, 1, 1, 1, 16'h0000, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h2e6c_0100);
    rfmw_reader_i.cmd(rfmw_pkg::OP_PORT, 0, 1, 1, 16'h0000, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h0000_0003);
    rfmw_reader_i.cmd(rfmw_pkg::OP_PORT, 1, 1, 1, 16'h0005, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h1e0f_0100);
    rd(rfmw_pkg::OFS_STATUS, 32'h0000_002e);
    rfmw_reader_i.cmd(rfmw_pkg::OP_WRITE, 1, 1, 1, 16'h0010, 32'h0000_0055);
    rd(rfmw_pkg::OFS_REPLY, 32'h00ff_0100);
    chk("reply crc", 32'h0000_00ff, {16'h0000, d[31:16]});
    rfmw_reader_i.cmd(rfmw_pkg::OP_QUERY, 1, 1, 1, 16'h0010, 32'h0000_0000);
    rd(rfmw_pkg::OFS_REPLY, 32'h00ff_0100);
    rfmw_reader_i.xfer(1'b0, 8'h20, 32'h0000_0000, d, e);
    chk("slave error", 32'h0000_0001, {31'h0000_0000, e});
    end_sim();
  end
endmodule
